// *** src/seeif_top.sv ***
// Slave front end of a 2 Kbit two-wire serial EEPROM
//
// Functional notes
// - Select code 1010 in upper nibble addresses the storage array.
// - Select code 0110 in upper nibble addresses the protection register.
// - Select bits b3..b1 must equal the three slot strap inputs.
// - Select byte arrives MSB first, b0 carries direction.
// - Device acknowledges each accepted select byte, each address byte and each writable data byte in the ninth bit time.
// - Write inhibit pin high rejects array and protection register writes.
// - With inhibit low, lower-half protection follows the stored lock state.
// - Once locked, addresses 00h to 7Fh stay unwritable until reset; reset clears the lock, which returns on stored_lock_i high or a protection write.
// - Below power-on threshold all commands are ignored.
// - Start is data falling while clock is high.
// - Start is watched except in write cycle; nothing answers without it.
// - Stop is data rising while clock is high; ends communication.
// - Read ended by no-ack and stop returns to standby.
// - Stop after a write launches the self-timed programming cycle.
// - Data line is open drain: pull low or release only.
// - Array holds 256 locations of eight bits, one address byte.
// - Direction bit 1 means read, 0 means write.
// - Select mismatch: no acknowledge, release bus, go to standby.
// - After locking, protection register code gets no response at all.
// - Incoming data bits are sampled on serial clock rising edge.
`default_nettype none
module seeif_top #(
  parameter int WRITE_TIME_NS = seeif_pkg::SEEIF_WRITE_TIME_NS
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic scl_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [seeif_pkg::SEEIF_SLOT_W-1:0] bus_slot_strap_inputs_i,
  input wire logic write_inhibit_pin_i,
  input wire logic supply_ok_i,
  input wire logic stored_lock_i,
  output logic lock_o,
  output logic write_busy_o
);
  import seeif_pkg::*;

  // ****************************************
  // Timing
  // ****************************************
  localparam int WR_CYC_RAW = (WRITE_TIME_NS + SEEIF_CLK_PERIOD_NS - 1) / SEEIF_CLK_PERIOD_NS;
  localparam int WR_CYC = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;
  // Timer counts down to zero inclusive, so load one less than the cycle count
  localparam logic [SEEIF_TMR_W-1:0] WR_LOAD = SEEIF_TMR_W'(WR_CYC - 1);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    seeif_state_e st;
    // Three-stage pin synchronisers
    logic [SEEIF_SYNC_W-1:0] scl_s;
    logic [SEEIF_SYNC_W-1:0] sda_s;
    logic [SEEIF_SYNC_W-1:0] wc_s;
    logic [SEEIF_SYNC_W-1:0] por_s;
    logic [SEEIF_SYNC_W-1:0] nvl_s;
    logic [SEEIF_SYNC_W-1:0][SEEIF_SLOT_W-1:0] slot_s;
    // Filtered pin levels
    logic scl_f;
    logic sda_f;
    logic wc_f;
    logic por_f;
    logic [SEEIF_SLOT_W-1:0] slot_f;
    // Transfer bookkeeping
    logic [3:0] cnt;
    logic is_read;
    logic is_prot;
    logic ack_ok;
    logic drv;
    logic wr_armed;
    logic [SEEIF_ADDR_W-1:0] addr;
    logic [SEEIF_ADDR_W-1:0] pend_addr;
    logic [SEEIF_DATA_W-1:0] pend;
    logic [SEEIF_DATA_W-1:0] txsh;
    logic [SEEIF_TMR_W-1:0] timer;
    logic lock;
    logic mem_we;
    logic sda_oe;
    logic busy;
    logic sda_out;
  } seeif_top_s;

  seeif_top_s r, n;

  logic [SEEIF_DATA_W-1:0] shift;
  logic [SEEIF_DATA_W-1:0] mem_rdata;
  logic [SEEIF_DATA_W-1:0] rd_byte;
  logic scl_new;
  logic sda_new;
  logic wc_new;
  logic por_new;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic last_bit;
  logic slot_hit;
  logic wr_ok;

  // ****************************************
  // Link-side capture and storage
  // ****************************************
  seeif_capture #(
    .W(SEEIF_DATA_W)
  ) u_capture (
    .scl_clk_i(scl_clk_i),
    .sda_i(sda_i),
    .shift_o(shift)
  );

  seeif_mem #(
    .AW(SEEIF_ADDR_W),
    .DW(SEEIF_DATA_W),
    .DEPTH(SEEIF_DEPTH)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(r.mem_we),
    .waddr_i(r.pend_addr),
    .wdata_i(r.pend),
    .raddr_i(r.addr),
    .rdata_o(mem_rdata)
  );

  // ****************************************
  // Protocol engine
  // ****************************************
  always_comb begin
    n = r;
    n.mem_we = 1'b0;
    n.sda_out = 1'b0;
    // Three-stage synchronisers; value changes once stages two and three agree
    n.scl_s = {r.scl_s[1:0], scl_i};
    n.sda_s = {r.sda_s[1:0], sda_i};
    n.wc_s = {r.wc_s[1:0], write_inhibit_pin_i};
    n.por_s = {r.por_s[1:0], supply_ok_i};
    n.nvl_s = {r.nvl_s[1:0], stored_lock_i};
    n.slot_s = {r.slot_s[1:0], bus_slot_strap_inputs_i};
    scl_new = (r.scl_s[2] == r.scl_s[1]) ? r.scl_s[2] : r.scl_f;
    sda_new = (r.sda_s[2] == r.sda_s[1]) ? r.sda_s[2] : r.sda_f;
    wc_new = (r.wc_s[2] == r.wc_s[1]) ? r.wc_s[2] : r.wc_f;
    por_new = (r.por_s[2] == r.por_s[1]) ? r.por_s[2] : r.por_f;
    n.scl_f = scl_new;
    n.sda_f = sda_new;
    n.wc_f = wc_new;
    n.por_f = por_new;
    if (r.slot_s[2] == r.slot_s[1]) begin
      n.slot_f = r.slot_s[2];
    end
    // Lock is sticky; the stored copy is merged in after every reset
    if ((r.nvl_s[2] == r.nvl_s[1]) && r.nvl_s[2]) begin
      n.lock = 1'b1;
    end
    scl_rise = scl_new & ~r.scl_f;
    scl_fall = ~scl_new & r.scl_f;
    start_seen = r.scl_f & scl_new & r.sda_f & ~sda_new;
    stop_seen = r.scl_f & scl_new & ~r.sda_f & sda_new;
    last_bit = (r.cnt == (SEEIF_BITS_PER_BYTE - 4'h1));
    // Capture word settles long before the synchronised rise reads it,
    // so this multi-bit crossing needs no further handshake
    slot_hit = (shift[SEEIF_SLOT_HI:SEEIF_SLOT_LO] == r.slot_f);
    // Inhibit pin gates every write; lock guards the lower half only
    wr_ok = ~r.wc_f & (r.is_prot | ~r.lock | r.addr[SEEIF_HALF_BIT]);
    rd_byte = r.is_prot ? SEEIF_PROT_READ_VAL : mem_rdata;

    if (!r.por_f) begin
      // Below threshold: stay idle and keep off the bus
      n.st = SEEIF_IDLE;
      n.sda_oe = 1'b0;
      n.wr_armed = 1'b0;
    end else if (r.st == SEEIF_WRCYC) begin
      // Bus lines are not watched while programming
      if (r.timer == '0) begin
        n.st = SEEIF_IDLE;
        if (r.is_prot) begin
          n.lock = 1'b1;
        end else begin
          n.mem_we = 1'b1;
        end
      end else begin
        n.timer = r.timer - SEEIF_TMR_W'(1);
      end
    end else if (start_seen) begin
      n.st = SEEIF_DEVSEL;
      n.cnt = '0;
      n.sda_oe = 1'b0;
      n.wr_armed = 1'b0;
    end else if (stop_seen) begin
      n.sda_oe = 1'b0;
      n.wr_armed = 1'b0;
      if (r.wr_armed) begin
        n.st = SEEIF_WRCYC;
        n.timer = WR_LOAD;
      end else begin
        n.st = SEEIF_STANDBY;
      end
    end else begin
      // A stop rides on the first high after an acked data byte; disarm once that high ends
      if (scl_fall) begin
        n.wr_armed = 1'b0;
      end
      case (r.st)
        SEEIF_DEVSEL: begin
          if (scl_rise) begin
            n.cnt = r.cnt + 4'h1;
            if (last_bit) begin
              // Whole select byte is in the capture register, b7 first
              n.is_read = (shift[SEEIF_RW_BIT] == SEEIF_RW_READ);
              n.cnt = '0;
              n.drv = 1'b0;
              n.ack_ok = 1'b1;
              if (slot_hit && shift[SEEIF_CODE_HI:SEEIF_CODE_LO] == SEEIF_MEM_CODE) begin
                n.is_prot = 1'b0;
                n.st = SEEIF_ACK_DS;
              end else if (slot_hit && !r.lock && shift[SEEIF_CODE_HI:SEEIF_CODE_LO] == SEEIF_PROT_CODE) begin
                n.is_prot = 1'b1;
                n.st = SEEIF_ACK_DS;
              end else begin
                n.st = SEEIF_STANDBY;
              end
            end
          end
        end
        SEEIF_ADDR, SEEIF_WDATA: begin
          if (scl_rise) begin
            n.cnt = r.cnt + 4'h1;
            if (last_bit) begin
              n.cnt = '0;
              n.drv = 1'b0;
              if (r.st == SEEIF_ADDR) begin
                n.addr = shift;
                n.ack_ok = 1'b1;
                n.st = SEEIF_ACK_AD;
              end else begin
                // Only the last byte of a page is held for programming
                n.pend = shift;
                n.pend_addr = r.addr;
                n.ack_ok = wr_ok;
                n.st = SEEIF_ACK_WD;
              end
            end
          end
        end
        SEEIF_ACK_DS, SEEIF_ACK_AD, SEEIF_ACK_WD: begin
          if (scl_fall) begin
            if (!r.drv) begin
              n.sda_oe = r.ack_ok;
              n.drv = 1'b1;
            end else begin
              n.sda_oe = 1'b0;
              n.drv = 1'b0;
              if (r.st == SEEIF_ACK_DS && r.is_read) begin
                n.st = SEEIF_RDATA;
                n.sda_oe = ~rd_byte[SEEIF_DATA_W-1];
                n.txsh = {rd_byte[SEEIF_DATA_W-2:0], 1'b1};
              end else if (r.st == SEEIF_ACK_DS) begin
                n.st = SEEIF_ADDR;
              end else begin
                n.st = SEEIF_WDATA;
                if (r.st == SEEIF_ACK_WD && r.ack_ok) begin
                  // Stop in the very next slot launches programming
                  n.wr_armed = 1'b1;
                  n.addr = {r.addr[SEEIF_ADDR_W-1:SEEIF_PAGE_BITS],
                            r.addr[SEEIF_PAGE_BITS-1:0] + SEEIF_PAGE_BITS'(1)};
                end
              end
            end
          end
        end
        SEEIF_RDATA: begin
          if (scl_rise) begin
            n.cnt = r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (r.cnt == SEEIF_BITS_PER_BYTE) begin
              n.sda_oe = 1'b0;
              n.cnt = '0;
              n.drv = 1'b0;
              n.st = SEEIF_RACK;
            end else begin
              n.sda_oe = ~r.txsh[SEEIF_DATA_W-1];
              n.txsh = {r.txsh[SEEIF_DATA_W-2:0], 1'b1};
            end
          end
        end
        SEEIF_RACK: begin
          if (scl_rise) begin
            if (shift[0]) begin
              // Master no-ack: wait for stop in standby
              n.st = SEEIF_STANDBY;
            end else begin
              // Sequential read wraps through the whole array
              n.addr = r.addr + SEEIF_ADDR_W'(1);
              n.drv = 1'b1;
            end
          end else if (scl_fall && r.drv) begin
            n.drv = 1'b0;
            n.st = SEEIF_RDATA;
            n.sda_oe = ~rd_byte[SEEIF_DATA_W-1];
            n.txsh = {rd_byte[SEEIF_DATA_W-2:0], 1'b1};
          end
        end
        SEEIF_IDLE, SEEIF_STANDBY: begin
          n.sda_oe = 1'b0;
        end
        default: begin
          n.st = SEEIF_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
    n.busy = (n.st == SEEIF_WRCYC);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
      // Pins idle high; filters start there so release shows no false edge
      r.scl_s <= '1;
      r.sda_s <= '1;
      r.scl_f <= 1'b1;
      r.sda_f <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Data pin is never driven high; only the enable moves
  assign sda_o = r.sda_out;
  assign sda_oe_o = r.sda_oe;
  assign lock_o = r.lock;
  assign write_busy_o = r.busy;
endmodule : seeif_top
`default_nettype wire

// *** src/seeif_pkg.sv ***
// Constants and types shared by the serial EEPROM bus front end
`default_nettype none
package seeif_pkg;
  // ****************************************
  // Select byte decoding
  // ****************************************
  localparam logic [3:0] SEEIF_MEM_CODE = 4'ha;
  localparam logic [3:0] SEEIF_PROT_CODE = 4'h6;
  localparam logic SEEIF_RW_READ = 1'b1;
  localparam int SEEIF_CODE_HI = 7;
  localparam int SEEIF_CODE_LO = 4;
  localparam int SEEIF_SLOT_HI = 3;
  localparam int SEEIF_SLOT_LO = 1;
  localparam int SEEIF_RW_BIT = 0;
  localparam int SEEIF_SLOT_W = 3;
  // ****************************************
  // Array geometry and lock
  // ****************************************
  localparam int SEEIF_ADDR_W = 8;
  localparam int SEEIF_DATA_W = 8;
  localparam int SEEIF_DEPTH = 256;
  localparam int SEEIF_PAGE_BITS = 4;
  localparam int SEEIF_HALF_BIT = 7;
  localparam logic [7:0] SEEIF_PROT_READ_VAL = 8'h00;
  // ****************************************
  // Bit timing
  // ****************************************
  localparam logic [3:0] SEEIF_BITS_PER_BYTE = 4'h8;
  localparam int SEEIF_CLK_PERIOD_NS = 50;
  localparam int SEEIF_WRITE_TIME_NS = 5000000;
  localparam int SEEIF_TMR_W = 24;
  localparam int SEEIF_SYNC_W = 3;
  // ****************************************
  // Protocol states
  // ****************************************
  typedef enum logic [3:0] {
    SEEIF_IDLE = 4'h0,
    SEEIF_DEVSEL = 4'h1,
    SEEIF_ACK_DS = 4'h2,
    SEEIF_ADDR = 4'h3,
    SEEIF_ACK_AD = 4'h4,
    SEEIF_WDATA = 4'h5,
    SEEIF_ACK_WD = 4'h6,
    SEEIF_RDATA = 4'h7,
    SEEIF_RACK = 4'h8,
    SEEIF_WRCYC = 4'h9,
    SEEIF_STANDBY = 4'ha
  } seeif_state_e;
endpackage : seeif_pkg
`default_nettype wire

// *** src/seeif_mem.sv ***
// Storage array with registered read port
`default_nettype none
module seeif_mem #(
  parameter int AW = seeif_pkg::SEEIF_ADDR_W,
  parameter int DW = seeif_pkg::SEEIF_DATA_W,
  parameter int DEPTH = seeif_pkg::SEEIF_DEPTH
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  import seeif_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] cells;
    logic [DW-1:0] rdata;
  } seeif_mem_s;

  seeif_mem_s r, n;

  // Contents are nonvolatile, so reset leaves them alone
  always_comb begin
    n = r;
    n.rdata = r.cells[raddr_i];
    if (we_i) begin
      n.cells[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    r <= n;
  end

  assign rdata_o = r.rdata;
endmodule : seeif_mem
`default_nettype wire

// *** src/seeif_capture.sv ***
// Serial-clock domain shift register for incoming data bits
`default_nettype none
module seeif_capture #(
  parameter int W = seeif_pkg::SEEIF_DATA_W
) (
  input wire logic scl_clk_i,
  input wire logic sda_i,
  output logic [W-1:0] shift_o
);
  import seeif_pkg::*;

  typedef struct packed {
    logic [W-1:0] shift;
  } seeif_cap_s;

  seeif_cap_s r, n;

  // No reset: the serial clock may stand still, bit counting lives elsewhere
  always_comb begin
    n = r;
    n.shift = {r.shift[W-2:0], sda_i};
  end

  always_ff @(posedge scl_clk_i) begin
    r <= n;
  end

  assign shift_o = r.shift;
endmodule : seeif_capture
`default_nettype wire

// *** dv/seeif_top_assertions.sv ***
// Port-level checks for the EEPROM bus front end
`default_nettype none
module seeif_top_assertions #(
  parameter int WRITE_TIME_NS = 2000
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic scl_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [seeif_pkg::SEEIF_SLOT_W-1:0] bus_slot_strap_inputs_i,
  input wire logic write_inhibit_pin_i,
  input wire logic supply_ok_i,
  input wire logic stored_lock_i,
  input wire logic lock_o,
  input wire logic write_busy_o
);
  import seeif_pkg::*;
  // ****************************************
  // Helpers
  // ****************************************
  localparam int BUSY_CLKS = WRITE_TIME_NS / SEEIF_CLK_PERIOD_NS;
  logic [23:0] busy_cnt_r;
  always_ff @(posedge clk_i) begin
    busy_cnt_r <= (write_busy_o && !reset_i) ? busy_cnt_r + 24'h1 : 24'h0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_supply_lost;
    !supply_ok_i [*8];
  endsequence
  sequence s_pull_held;
    sda_oe_o [*8];
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  chk_drain_only: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  chk_lock_sticky: assert property (lock_o |=> lock_o)
    else $error("lower half lock dropped");
  chk_lock_follow: assert property ($rose(stored_lock_i) |-> ##[1:8] lock_o)
    else $error("stored lock not reported");
  chk_busy_length: assert property ($fell(write_busy_o) |->
    (busy_cnt_r >= BUSY_CLKS - 1) && (busy_cnt_r <= BUSY_CLKS + 1))
    else $error("programming time wrong");
  chk_busy_quiet: assert property (write_busy_o |-> !sda_oe_o)
    else $error("bus driven while programming");
  chk_supply_idle: assert property (s_supply_lost |-> !sda_oe_o)
    else $error("bus driven with supply low");
  chk_pull_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed with clock high");
  chk_pull_stands: assert property ($rose(sda_oe_o) |=> s_pull_held)
    else $error("pull released too early");
  chk_inhibit_write: assert property ($rose(write_busy_o) |-> !write_inhibit_pin_i)
    else $error("write launched while inhibited");
  chk_busy_after_stop: assert property ($rose(write_busy_o) |-> scl_i && sda_i)
    else $error("write launched without stop");
endmodule : seeif_top_assertions
`default_nettype wire

// *** dv/seeif_master.sv ***
// Two-wire bus master model that supplies the serial clock
`default_nettype none
module seeif_master (
  input wire logic link_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1; // Clock stands high outside frames
    sda_oe_o = 1'b0;
  end
  task automatic quarter();
    repeat (8) @(posedge link_clk_i);
  endtask : quarter
  // Data falls while clock high
  task automatic start();
    quarter();
    sda_oe_o <= 1'b0;
    quarter();
    scl_o <= 1'b1;
    quarter();
    sda_oe_o <= 1'b1;
    quarter();
    scl_o <= 1'b0;
  endtask : start
  // Data rises while clock high
  task automatic stop();
    quarter();
    sda_oe_o <= 1'b1;
    quarter();
    scl_o <= 1'b1;
    quarter();
    sda_oe_o <= 1'b0;
    quarter();
  endtask : stop
  // Data moves only with clock low; sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    quarter();
    sda_oe_o <= ~b;
    quarter();
    scl_o <= 1'b1;
    quarter();
    s = sda_i;
    quarter();
    scl_o <= 1'b0;
  endtask : bit_io
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask : rbyte
endmodule : seeif_master
`default_nettype wire

// *** dv/seeif_top_tb_top.sv ***
// Self-checking bench for the EEPROM bus front end
`default_nettype none
module seeif_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import seeif_pkg::*;
  // Long enough that a select can land inside the write
  localparam int WRITE_TIME_NS = 40000;
  logic clk;
  logic link_clk;
  logic reset = 1'b1;
  logic scl;
  logic m_oe;
  logic dut_sda;
  logic dut_oe;
  logic sda_w;
  logic [2:0] straps = 3'h5;
  logic inhibit = 1'b0;
  logic supply = 1'b1;
  logic stored_lock = 1'b0;
  logic lock;
  logic busy;
  int fails = 0;
  int tests_run = 0;
  // Pull-up wins when nobody pulls
  assign sda_w = (dut_oe ? dut_sda : 1'b1) & ~m_oe;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #32 link_clk = ~link_clk;
  end
  seeif_top #(.WRITE_TIME_NS(WRITE_TIME_NS)) DUT (.clk_i(clk), .reset_i(reset), .scl_clk_i(scl), .scl_i(scl),
    .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_o(dut_oe), .bus_slot_strap_inputs_i(straps),
    .write_inhibit_pin_i(inhibit), .supply_ok_i(supply), .stored_lock_i(stored_lock), .lock_o(lock),
    .write_busy_o(busy));
  seeif_master u_master (.link_clk_i(link_clk), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(m_oe));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic sel(input logic [3:0] code, input logic [2:0] slot, input logic rw, output logic ack);
    u_master.start();
    u_master.wbyte({code, slot, rw}, ack);
  endtask : sel
  task automatic write1(input logic [3:0] code, input logic [7:0] a, input logic [7:0] d, output logic [2:0] k);
    sel(code, straps, 1'b0, k[2]);
    u_master.wbyte(a, k[1]);
    u_master.wbyte(d, k[0]);
    u_master.stop();
  endtask : write1
  task automatic prog_wait(input logic exp);
    logic seen = 1'b0;
    for (int i = 0; i < 300 && !seen; i++) begin
      @(negedge clk);
      seen = busy;
    end
    check("write busy", {7'h0, seen}, {7'h0, exp});
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clk);
    check("write done", {7'h0, busy}, 8'h00);
    // Back on the rising edge so the caller drives inputs there
    @(posedge clk);
  endtask : prog_wait
  task automatic t_write_read();
    logic [2:0] k;
    logic [7:0] d;
    logic [7:0] addrs [3] = '{8'h00, 8'h7f, 8'hff};
    foreach (addrs[i]) begin
      write1(SEEIF_MEM_CODE, addrs[i], addrs[i] ^ 8'h5a, k);
      check("write acks", {5'h0, k}, 8'h07);
      prog_wait(1'b1);
      sel(SEEIF_MEM_CODE, straps, 1'b0, k[2]);
      u_master.wbyte(addrs[i], k[1]);
      sel(SEEIF_MEM_CODE, straps, 1'b1, k[0]);
      u_master.rbyte(1'b0, d);
      u_master.stop();
      check("read acks", {5'h0, k}, 8'h07);
      check("read data", d, addrs[i] ^ 8'h5a);
    end
    // Sequential read from the top location wraps to location zero
    sel(SEEIF_MEM_CODE, straps, 1'b0, k[2]);
    u_master.wbyte(8'hff, k[1]);
    sel(SEEIF_MEM_CODE, straps, 1'b1, k[0]);
    check("seq read acks", {5'h0, k}, 8'h07);
    u_master.rbyte(1'b1, d);
    check("seq read first", d, 8'hff ^ 8'h5a);
    u_master.rbyte(1'b0, d);
    u_master.stop();
    check("seq read next", d, 8'h00 ^ 8'h5a);
  endtask : t_write_read
  task automatic t_busy();
    logic [2:0] k;
    logic a;
    write1(SEEIF_MEM_CODE, 8'h40, 8'h11, k);
    sel(SEEIF_MEM_CODE, straps, 1'b0, a);
    check("select during write", {7'h0, a}, 8'h00);
    u_master.stop();
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clk);
    check("busy ends", {7'h0, busy}, 8'h00);
    u_master.wbyte({SEEIF_MEM_CODE, straps, 1'b0}, a);
    check("byte without start", {7'h0, a}, 8'h00);
    u_master.stop();
  endtask : t_busy
  task automatic t_mismatch();
    logic a;
    logic [3:0] codes [5] = '{SEEIF_MEM_CODE, SEEIF_MEM_CODE, SEEIF_MEM_CODE, 4'hb, 4'h2};
    logic [2:0] slots [5] = '{straps ^ 3'h1, straps ^ 3'h2, straps ^ 3'h4, straps, straps};
    foreach (codes[i]) begin
      sel(codes[i], slots[i], 1'b1, a);
      check("foreign select", {7'h0, a}, 8'h00);
      u_master.stop();
    end
  endtask : t_mismatch
  task automatic t_supply();
    logic a;
    @(posedge clk);
    supply <= 1'b0;
    repeat (10) @(posedge clk);
    sel(SEEIF_MEM_CODE, straps, 1'b0, a);
    check("select low supply", {7'h0, a}, 8'h00);
    u_master.stop();
    supply <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : t_supply
  task automatic t_prot();
    logic [2:0] k;
    logic [7:0] d;
    sel(SEEIF_PROT_CODE, straps, 1'b1, k[0]);
    u_master.rbyte(1'b0, d);
    u_master.stop();
    check("protect read ack", {7'h0, k[0]}, 8'h01);
    check("protect read data", d, SEEIF_PROT_READ_VAL);
    @(posedge clk);
    inhibit <= 1'b1;
    write1(SEEIF_MEM_CODE, 8'h90, 8'h22, k);
    check("inhibited data", {5'h0, k}, 8'h06);
    prog_wait(1'b0);
    write1(SEEIF_PROT_CODE, 8'h00, 8'h00, k);
    check("inhibited protect", {5'h0, k}, 8'h06);
    prog_wait(1'b0);
    inhibit <= 1'b0;
    write1(SEEIF_PROT_CODE, 8'h00, 8'h00, k);
    check("protect write", {5'h0, k}, 8'h07);
    prog_wait(1'b1);
    check("lock set", {7'h0, lock}, 8'h01);
    write1(SEEIF_MEM_CODE, 8'h7f, 8'h33, k);
    check("locked low half", {5'h0, k}, 8'h06);
    prog_wait(1'b0);
    sel(SEEIF_PROT_CODE, straps, 1'b0, k[0]);
    check("protect code gone", {7'h0, k[0]}, 8'h00);
    u_master.stop();
    write1(SEEIF_MEM_CODE, 8'h80, 8'hc3, k);
    check("upper half open", {5'h0, k}, 8'h07);
    prog_wait(1'b1);
  endtask : t_prot
  task automatic t_stored();
    @(posedge clk);
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (10) @(posedge clk);
    stored_lock <= 1'b1;
    repeat (10) @(posedge clk);
    check("stored lock", {7'h0, lock}, 8'h01);
  endtask : t_stored
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (10) @(posedge clk);
    t_write_read();
    t_busy();
    t_mismatch();
    t_supply();
    t_prot();
    t_stored();
    print_verdict();
  end
  // About 30000 cycles expected
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule : seeif_top_tb_top
bind seeif_top seeif_top_assertions #(.WRITE_TIME_NS(WRITE_TIME_NS)) u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .scl_clk_i(scl_clk_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .bus_slot_strap_inputs_i(bus_slot_strap_inputs_i), .write_inhibit_pin_i(write_inhibit_pin_i),
  .supply_ok_i(supply_ok_i), .stored_lock_i(stored_lock_i), .lock_o(lock_o), .write_busy_o(write_busy_o));
`default_nettype wire
